// ### design/cbc_top.sv
// module: charger indicator, interrupt, fault, battery switch and pulse control
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cbc_top #(
   parameter int unsigned BLINK_CYC = cbc_pkg::BLINK_MS * cbc_pkg::CLK_KHZ,
   parameter int unsigned SHIP_DLY_CYC = cbc_pkg::SHIP_DLY_MS * cbc_pkg::CLK_KHZ,
   parameter int unsigned DEGL_CYC = cbc_pkg::DEGL_MS * cbc_pkg::CLK_KHZ,
   parameter int unsigned QON_RST_CYC = cbc_pkg::QON_RST_MS * cbc_pkg::CLK_KHZ,
   parameter int unsigned SW_RST_CYC = cbc_pkg::SW_RST_MS * cbc_pkg::CLK_KHZ,
   parameter int unsigned PULSE_CYC = cbc_pkg::PULSE_MS * cbc_pkg::CLK_KHZ
)(
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire cbc_pkg::cbc_ana_t ana,
   input wire logic push_button_pin_n,
   input wire logic [5:0] limit_resistor_pin,
   output logic stat_o,
   output logic stat_oe,
   output logic host_int_n,
   output cbc_pkg::cbc_drive_t drive
);
   logic [1:0] rs_q;
   logic rst_n;
   logic [7:0] ctrl_q, ctrl_d;
   logic [5:0] limit_resistor_pin_q, limit_resistor_pin_d;
   cbc_pkg::cbc_fault_t live, latched_q, latched_d, fault_rd;
   logic [3:0] prev_q;
   logic [11:0] int_cnt_q, int_cnt_d;
   logic int_n_q;
   logic [31:0] pb_cnt_q, blink_cnt_q, tm_q, pcnt_q;
   logic blink_q, low_q, stat_oe_q;
   logic [3:0] phase_q;
   cbc_pkg::cbc_sw_t st_q, st_d;
   cbc_pkg::cbc_drive_t drive_q, drive_d;

   function automatic logic [5:0] min6(input logic [5:0] a, input logic [5:0] b);
      min6 = (a < b) ? a : b;
   endfunction

   // reset release through two flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rs_q <= 2'b00;
      end else begin
         rs_q <= {rs_q[0], 1'b1};
      end
   end
   assign rst_n = rs_q[1];

   // apb decode: zero wait states, error on unmapped offsets
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire hit_ctrl = (paddr == cbc_pkg::OFF_CTRL);
   wire hit_lim = (paddr == cbc_pkg::OFF_LIMIT);
   wire hit_flt = (paddr == cbc_pkg::OFF_FAULT);
   wire hit_st = (paddr == cbc_pkg::OFF_STATUS);
   wire mapped = hit_ctrl | hit_lim | hit_flt | hit_st;
   wire w_ctrl = wr & hit_ctrl;
   wire reg_rst = w_ctrl & pwdata[cbc_pkg::B_REG_RST];
   wire rd_fault = rd & hit_flt;
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   // input qualification and event edges
   wire pg = ana.vbus_gt_bat & ana.vbus_lt_ov & ana.vbus_ok_load;
   wire busy = ctrl_q[cbc_pkg::B_UP] | ctrl_q[cbc_pkg::B_DN];
   wire pb_degl = (pb_cnt_q == DEGL_CYC);
   wire pb_hold = (pb_cnt_q == QON_RST_CYC);
   wire pg_rise = pg & ~prev_q[0];
   wire pg_fall = ~pg & prev_q[0];
   wire src_rise = ana.src_ident & ~prev_q[1];
   wire done_rise = ana.chg_done & ~prev_q[2];
   wire boost_off = ana.boost_tshut | (ana.boost_mode & ana.boost_ts);
   wire up_phase = ctrl_q[cbc_pkg::B_UP] & ~low_q;
   wire [31:0] phase_len = up_phase ? 32'(3 * PULSE_CYC) : PULSE_CYC;
   wire phase_end = busy & (pcnt_q >= phase_len - 32'd1);
   wire pulse_done = phase_end & (phase_q == cbc_pkg::PULSE_PHASES - 4'h1);

   // live fault vector; buck shutdown reports code 10
   always_comb begin
      live.boost = ana.boost_ov | boost_off;
      live.bat = ana.bat_ov;
      live.ntc = ana.ntc;
      if (ana.buck_tshut) begin
         live.chg = cbc_pkg::CF_TSHUT;
      end else if (ana.in_ov | ana.sys_ov) begin
         live.chg = cbc_pkg::CF_INPUT;
      end else if (ana.timer_exp) begin
         live.chg = cbc_pkg::CF_TIMER;
      end else begin
         live.chg = cbc_pkg::CF_NONE;
      end
   end

   // a read hands back the latched copy (ntc bits live) and reloads it with live state
   logic [6:0] prev_flt_q;
   wire [6:0] flt_new = live & ~prev_flt_q;
   wire fault_evt = |flt_new;
   wire fault_int = fault_evt & (latched_q == '0);
   always_comb begin
      latched_d = latched_q | live;
      if (rd_fault) begin
         latched_d = live | flt_new;
      end
      fault_rd = latched_q;
      fault_rd.ntc = live.ntc;
   end

   // control and limit registers with hardware updates
   always_comb begin
      ctrl_d = ctrl_q;
      limit_resistor_pin_d = limit_resistor_pin_q;
      if (w_ctrl) begin
         ctrl_d[4:0] = pwdata[4:0];
         ctrl_d[cbc_pkg::B_LIM_EN] = pwdata[cbc_pkg::B_LIM_EN];
         if (ctrl_q[cbc_pkg::B_PP_EN] & ~busy) begin
            ctrl_d[cbc_pkg::B_UP] = pwdata[cbc_pkg::B_UP];
            ctrl_d[cbc_pkg::B_DN] = pwdata[cbc_pkg::B_DN] & ~pwdata[cbc_pkg::B_UP];
         end
      end
      if (wr & hit_lim) begin
         limit_resistor_pin_d = pwdata[5:0];
      end
      if (pg_rise | (pb_degl & (st_q == cbc_pkg::SW_SHIP))) begin
         ctrl_d[cbc_pkg::B_SW_OFF] = 1'b0;
      end
      if (pulse_done | ~ctrl_d[cbc_pkg::B_PP_EN]) begin
         ctrl_d[cbc_pkg::B_UP] = 1'b0;
         ctrl_d[cbc_pkg::B_DN] = 1'b0;
      end
      if (reg_rst) begin
         ctrl_d = cbc_pkg::CTRL_RST;
         limit_resistor_pin_d = cbc_pkg::LIMIT_RST;
      end
      if (boost_off) begin
         ctrl_d[cbc_pkg::B_SW_OFF] = 1'b1;
      end
   end

   // battery switch sequencer
   wire sw_off = ctrl_q[cbc_pkg::B_SW_OFF];
   always_comb begin
      st_d = st_q;
      case (st_q)
         cbc_pkg::SW_ON: begin
            if (sw_off & (boost_off | ~ctrl_q[cbc_pkg::B_DLY_SEL])) begin
               st_d = cbc_pkg::SW_SHIP;
            end else if (sw_off) begin
               st_d = cbc_pkg::SW_DLY;
            end else if (pb_hold & ~pg & ctrl_q[cbc_pkg::B_RST_EN]) begin
               st_d = cbc_pkg::SW_RST;
            end
         end
         cbc_pkg::SW_DLY: begin
            if (~sw_off) begin
               st_d = cbc_pkg::SW_ON;
            end else if (boost_off | (tm_q >= SHIP_DLY_CYC - 32'd1)) begin
               st_d = cbc_pkg::SW_SHIP;
            end
         end
         cbc_pkg::SW_SHIP: begin
            if (~sw_off) begin
               st_d = cbc_pkg::SW_ON;
            end
         end
         cbc_pkg::SW_RST: begin
            if (tm_q >= SW_RST_CYC - 32'd1) begin
               st_d = cbc_pkg::SW_ON;
            end
         end
         default: st_d = cbc_pkg::SW_ON;
      endcase
   end

   // applied limit, thermal reactions and switch outputs
   wire [5:0] base_lim = ctrl_q[cbc_pkg::B_LIM_EN] ? min6(limit_resistor_pin_q, limit_resistor_pin) : limit_resistor_pin_q;
   always_comb begin
      drive_d.limit = (low_q & busy) ? cbc_pkg::LIM_100MA : base_lim;
      drive_d.lim_mon_en = ctrl_q[cbc_pkg::B_LIM_EN];
      drive_d.term_en = ~ana.thermal_reg;
      drive_d.timer_half = ana.thermal_reg;
      drive_d.conv_en = ~ana.buck_tshut;
      drive_d.batsw_on = ~ana.buck_tshut & ((st_q == cbc_pkg::SW_ON) | (st_q == cbc_pkg::SW_DLY));
   end

   // interrupt pulse timer: one pulse, events during it merge
   wire int_evt = src_rise | pg_rise | pg_fall | done_rise | fault_int;
   assign int_cnt_d = (int_cnt_q != 12'h000) ? int_cnt_q - 12'h001 :
                      (int_evt ? cbc_pkg::INT_CYC : 12'h000);

   // indicator: low while charging, blink on suspend, released otherwise
   wire suspend = (ana.charging & (ana.in_ov | ana.sys_ov | ana.timer_exp | (ana.ntc != 3'h0)))
                  | (ana.boost_mode & ana.boost_ts);
   wire stat_d = ~ctrl_q[cbc_pkg::B_IND_DIS]
                 & (suspend ? blink_q : (ana.charging & ~ana.chg_done));
   assign stat_o = 1'b0;
   assign stat_oe = stat_oe_q;
   assign host_int_n = int_n_q;
   assign drive = drive_q;

   // register read mux
   always_comb begin
      prdata = 32'h0000_0000;
      if (hit_ctrl) begin
         prdata[7:0] = ctrl_q;
      end else if (hit_lim) begin
         prdata[5:0] = limit_resistor_pin_q;
      end else if (hit_flt) begin
         prdata[6:0] = fault_rd;
      end else if (hit_st) begin
         prdata[5:0] = drive_q.limit;
         prdata[8] = ana.thermal_reg;
         prdata[9] = pg;
         prdata[10] = drive_q.batsw_on;
         prdata[11] = busy;
      end
   end

   // state registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= cbc_pkg::CTRL_RST;
         limit_resistor_pin_q <= cbc_pkg::LIMIT_RST;
         latched_q <= '0;
         prev_flt_q <= '0;
         prev_q <= 4'h0;
         int_cnt_q <= 12'h000;
         int_n_q <= 1'b1;
         st_q <= cbc_pkg::SW_ON;
         drive_q <= '0;
         stat_oe_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         limit_resistor_pin_q <= limit_resistor_pin_d;
         latched_q <= latched_d;
         prev_flt_q <= live;
         prev_q <= {1'b0, ana.chg_done, ana.src_ident, pg};
         int_cnt_q <= int_cnt_d;
         int_n_q <= (int_cnt_d == 12'h000);
         st_q <= st_d;
         drive_q <= drive_d;
         stat_oe_q <= stat_d;
      end
   end

   // button, blink and sequencer counters
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pb_cnt_q <= 32'h0;
         blink_cnt_q <= 32'h0;
         blink_q <= 1'b0;
         tm_q <= 32'h0;
      end else begin
         pb_cnt_q <= push_button_pin_n ? 32'h0 :
                     ((pb_cnt_q > QON_RST_CYC) ? pb_cnt_q : pb_cnt_q + 32'h1);
         tm_q <= (st_d != st_q) ? 32'h0 : tm_q + 32'h1;
         if (!suspend || blink_cnt_q >= BLINK_CYC - 32'd1) begin
            blink_cnt_q <= 32'h0;
            blink_q <= suspend & ~blink_q;
         end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
         end
      end
   end

   // current pulse phases; abort or finish returns to the programmed limit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pcnt_q <= 32'h0;
         phase_q <= 4'h0;
         low_q <= 1'b0;
      end else if (!(ctrl_d[cbc_pkg::B_UP] | ctrl_d[cbc_pkg::B_DN])) begin
         pcnt_q <= 32'h0;
         phase_q <= 4'h0;
         low_q <= 1'b0;
      end else if (phase_end) begin
         pcnt_q <= 32'h0;
         phase_q <= phase_q + 4'h1;
         low_q <= ~low_q;
      end else begin
         pcnt_q <= pcnt_q + 32'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_stat_disable: assert property (ctrl_q[cbc_pkg::B_IND_DIS] |=> !stat_oe)
      else $error("indicator driven while disabled");
   a_stat_charging: assert property (ana.charging && !ana.chg_done && !suspend
      && !ctrl_q[cbc_pkg::B_IND_DIS] |=> stat_oe)
      else $error("indicator not low while charging");
   a_int_width: assert property ($fell(host_int_n) |-> int_cnt_q == cbc_pkg::INT_CYC)
      else $error("interrupt pulse length wrong");
   a_fault_mask: assert property (fault_evt && !int_evt && latched_q != '0
      && int_cnt_q == 12'h000 |=> host_int_n)
      else $error("fault interrupt while faults unread");
   a_fault_hold: assert property (!$past(rd_fault) |-> (($past(latched_q) & ~latched_q) == '0))
      else $error("latched fault lost without read");
   a_pp_ignore: assert property (w_ctrl && !ctrl_q[cbc_pkg::B_PP_EN] && !busy |=> !busy)
      else $error("request accepted while protocol disabled");
   a_pp_abort: assert property ($fell(ctrl_q[cbc_pkg::B_PP_EN]) |-> !busy ##1
      drive.limit == $past(base_lim))
      else $error("pulse sequence not aborted");
   a_limit_min: assert property (ctrl_q[cbc_pkg::B_LIM_EN] && !busy
      |=> drive.limit <= $past(limit_resistor_pin_q) && drive.limit <= $past(limit_resistor_pin))
      else $error("applied limit above pin or register");
   a_rst_skip: assert property (!ctrl_q[cbc_pkg::B_RST_EN] && st_q == cbc_pkg::SW_ON
      |=> st_q != cbc_pkg::SW_RST)
      else $error("reset sequence while disabled");
   a_tshut_off: assert property (ana.buck_tshut |=> !drive.batsw_on && !drive.conv_en)
      else $error("switch or converter on in thermal shutdown");

   c_pulse_done: cover property (busy ##1 !busy && ctrl_q[cbc_pkg::B_PP_EN]);
   c_ship_mode: cover property (st_q == cbc_pkg::SW_SHIP ##1 st_q == cbc_pkg::SW_ON);
   c_sys_reset: cover property (st_q == cbc_pkg::SW_RST);
   c_int_pulse: cover property ($rose(host_int_n));
endmodule
`default_nettype wire

// ### design/cbc_pkg.sv
// package: register map, timing constants and carriers of the charger control block
`default_nettype none
package cbc_pkg;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_LIMIT = 8'h04;
   localparam logic [7:0] OFF_FAULT = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   // control register bit positions
   localparam int B_IND_DIS = 0;
   localparam int B_SW_OFF = 1;
   localparam int B_DLY_SEL = 2;
   localparam int B_RST_EN = 3;
   localparam int B_PP_EN = 4;
   localparam int B_UP = 5;
   localparam int B_DN = 6;
   localparam int B_LIM_EN = 7;
   localparam int B_REG_RST = 8;
   localparam logic [7:0] CTRL_RST = 8'h08;
   localparam logic [5:0] LIMIT_RST = 6'h08;
   localparam logic [5:0] LIM_100MA = 6'h00;
   // charge fault field codes
   localparam logic [1:0] CF_NONE = 2'h0;
   localparam logic [1:0] CF_INPUT = 2'h1;
   localparam logic [1:0] CF_TSHUT = 2'h2;
   localparam logic [1:0] CF_TIMER = 2'h3;
   // timing
   localparam int unsigned CLK_KHZ = 10_000;
   localparam int unsigned INT_US = 256;
   localparam logic [11:0] INT_CYC = 12'(INT_US * CLK_KHZ / 1000);
   localparam int unsigned BLINK_MS = 500;
   localparam int unsigned SHIP_DLY_MS = 10_000;
   localparam int unsigned DEGL_MS = 1_000;
   localparam int unsigned QON_RST_MS = 15_000;
   localparam int unsigned SW_RST_MS = 250;
   localparam int unsigned PULSE_MS = 100;
   localparam logic [3:0] PULSE_PHASES = 4'h8;
   typedef struct packed {
      logic vbus_gt_bat;
      logic vbus_lt_ov;
      logic vbus_ok_load;
      logic src_ident;
      logic charging;
      logic chg_done;
      logic in_ov;
      logic sys_ov;
      logic timer_exp;
      logic bat_ov;
      logic boost_mode;
      logic boost_ov;
      logic boost_ts;
      logic boost_tshut;
      logic buck_tshut;
      logic thermal_reg;
      logic [2:0] ntc;
   } cbc_ana_t;
   typedef struct packed {
      logic boost;
      logic [1:0] chg;
      logic bat;
      logic [2:0] ntc;
   } cbc_fault_t;
   typedef struct packed {
      logic batsw_on;
      logic conv_en;
      logic term_en;
      logic timer_half;
      logic lim_mon_en;
      logic [5:0] limit;
   } cbc_drive_t;
   typedef enum logic [1:0] {SW_ON, SW_DLY, SW_SHIP, SW_RST} cbc_sw_t;
endpackage
`default_nettype wire

// ### sim/cbc_adapter_model.sv
// adapter side model: counts how often the input limit drops to the 100 mA step
`timescale 1ns/1ps
`default_nettype none
module cbc_adapter_model (
   input wire logic clk,
   input wire logic [5:0] limit,
   input wire logic clr,
   output logic [3:0] lows
);
   logic [5:0] prev_q;
   // count entries into the low step; each entry is one current pulse seen on vbus
   always_ff @(posedge clk) begin
      prev_q <= limit;
      if (clr) begin
         lows <= 4'h0;
      end else if (limit == cbc_pkg::LIM_100MA && prev_q != cbc_pkg::LIM_100MA) begin
         lows <= lows + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ### sim/cbc_top_tb.sv
// testbench of the charger control block: apb host, analog stimulus, output checks
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
`define WAITC(c) begin for (wn = 0; wn < 3000 && !(c); wn++) @(posedge clk); if (wn == 3000) begin err_total++; report_and_stop(); end end
module cbc_top_tb;
   localparam int SW = 8;
   localparam logic [31:0] IND = 32'h1 << cbc_pkg::B_IND_DIS;
   localparam logic [31:0] OFF = 32'h1 << cbc_pkg::B_SW_OFF;
   localparam logic [31:0] DLY = 32'h1 << cbc_pkg::B_DLY_SEL;
   localparam logic [31:0] PPE = 32'h1 << cbc_pkg::B_PP_EN;
   localparam logic [31:0] UP = 32'h1 << cbc_pkg::B_UP;
   localparam logic [31:0] DN = 32'h1 << cbc_pkg::B_DN;
   localparam logic [31:0] LEN = 32'h1 << cbc_pkg::B_LIM_EN;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, stat_o, stat_oe, host_int_n;
   logic push_button_pin_n, clr, bad;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, mon_m, mon_e, b;
   logic [5:0] limit_resistor_pin, lim;
   logic [3:0] lows;
   cbc_pkg::cbc_ana_t ana;
   cbc_pkg::cbc_drive_t drive;
   int err_total, comparisons, wn, n;
   logic [31:0] eq[$];
   logic [31:0] mq[$];
   logic s;
   cbc_top #(.BLINK_CYC(20), .SHIP_DLY_CYC(30), .DEGL_CYC(10), .QON_RST_CYC(40),
      .SW_RST_CYC(SW), .PULSE_CYC(5)) DUT (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ana(ana), .push_button_pin_n(push_button_pin_n),
      .limit_resistor_pin(limit_resistor_pin), .stat_o(stat_o), .stat_oe(stat_oe),
      .host_int_n(host_int_n), .drive(drive));
   cbc_adapter_model adapter (.clk(clk), .limit(drive.limit), .clr(clr), .lows(lows));
   // clock at 10 mhz
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task report_and_stop();
      if (err_total == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task cyc(input int c);
      repeat (c) @(posedge clk);
   endtask
   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (wn = 0; wn < 3000; wn++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (wn == 3000) begin
         err_total++;
         report_and_stop();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      mq.push_back(m);
      eq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task wc(input logic [31:0] v);
      apb(1'b1, cbc_pkg::OFF_CTRL, v);
   endtask
   task vbus(input logic v);
      ana.vbus_gt_bat <= v;
      ana.vbus_lt_ov <= v;
      ana.vbus_ok_load <= v;
   endtask
   // waits for one interrupt pulse and measures its width
   task pulse();
      `WAITC(host_int_n === 1'b0)
      n = 0;
      while (host_int_n === 1'b0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      `CHK(n, int'(cbc_pkg::INT_CYC))
   endtask
   // read monitor: takes the oldest note whenever read data is accepted
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1) begin
         if (!pwrite) begin
            mon_m = mq.pop_front();
            mon_e = eq.pop_front();
            `CHK(prdata & mon_m, mon_e)
         end
         `CHK(pslverr, (paddr > 8'h0c))
      end
   end
   // main sequence
   initial begin
      {resetn, psel, penable, pwrite, paddr, pwdata, clr, ana} = '0;
      push_button_pin_n = 1'b1;
      limit_resistor_pin = 6'h3f;
      void'($urandom(32'hf725));
      lim = 6'($urandom_range(63, 9));
      cyc(8);
      resetn <= 1'b1;
      cyc(3);
      rd(cbc_pkg::OFF_CTRL, '1, 32'(cbc_pkg::CTRL_RST));
      rd(cbc_pkg::OFF_LIMIT, '1, 32'(cbc_pkg::LIMIT_RST));
      rd(8'h10, '1, 32'h0);
      vbus(1'b1);
      pulse();
      rd(cbc_pkg::OFF_STATUS, 32'h200, 32'h200);
      ana.vbus_lt_ov <= 1'b0;
      pulse();
      rd(cbc_pkg::OFF_STATUS, 32'h200, 32'h0);
      ana.vbus_lt_ov <= 1'b1;
      pulse();
      ana.src_ident <= 1'b1;
      pulse();
      `CHK(stat_o, 1'b0)
      ana.charging <= 1'b1;
      cyc(3);
      `CHK(stat_oe, 1'b1)
      wc(IND);
      cyc(2);
      `CHK(stat_oe, 1'b0)
      wc(32'h8);
      ana.charging <= 1'b0;
      ana.chg_done <= 1'b1;
      pulse();
      `CHK(stat_oe, 1'b0)
      ana.chg_done <= 1'b0;
      ana.timer_exp <= 1'b1;
      ana.charging <= 1'b1;
      pulse();
      s = stat_oe;
      n = 0;
      repeat (40) begin
         @(posedge clk);
         if (stat_oe !== s) n++;
         s = stat_oe;
      end
      `CHK(n, 2)
      ana.bat_ov <= 1'b1;
      bad = 1'b0;
      repeat (6) begin
         @(posedge clk);
         bad = bad | (host_int_n !== 1'b1);
      end
      `CHK(bad, 1'b0)
      ana.timer_exp <= 1'b0;
      ana.bat_ov <= 1'b0;
      rd(cbc_pkg::OFF_FAULT, 32'h7f, 32'h38);
      rd(cbc_pkg::OFF_FAULT, 32'h7f, 32'h0);
      ana.thermal_reg <= 1'b1;
      cyc(3);
      `CHK({drive.term_en, drive.timer_half}, 2'b01)
      rd(cbc_pkg::OFF_STATUS, 32'h100, 32'h100);
      ana.thermal_reg <= 1'b0;
      ana.buck_tshut <= 1'b1;
      pulse();
      `CHK({drive.batsw_on, drive.conv_en}, 2'b00)
      ana.buck_tshut <= 1'b0;
      cyc(3);
      `CHK(drive.batsw_on, 1'b1)
      rd(cbc_pkg::OFF_FAULT, 32'h30, 32'h20);
      rd(cbc_pkg::OFF_FAULT, 32'h7f, 32'h0);
      apb(1'b1, cbc_pkg::OFF_LIMIT, 32'(lim));
      limit_resistor_pin <= 6'h03;
      wc(LEN);
      cyc(2);
      `CHK({drive.lim_mon_en, drive.limit}, {1'b1, 6'h03})
      rd(cbc_pkg::OFF_STATUS, 32'h3f, 32'h3);
      limit_resistor_pin <= 6'h3f;
      cyc(2);
      `CHK(drive.limit, lim)
      wc(32'h0);
      limit_resistor_pin <= 6'h03;
      cyc(2);
      `CHK({drive.lim_mon_en, drive.limit}, {1'b0, lim})
      wc(UP);
      rd(cbc_pkg::OFF_CTRL, UP, 32'h0);
      `CHK(drive.limit, lim)
      for (int i = 0; i < 2; i++) begin
         b = (i == 0) ? UP : DN;
         wc(PPE);
         clr <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         wc(PPE | b);
         rd(cbc_pkg::OFF_CTRL, b, b);
         cyc(100);
         rd(cbc_pkg::OFF_CTRL, b, 32'h0);
         `CHK(drive.limit, lim)
         `CHK(lows, 4'h4)
      end
      wc(PPE | DN);
      `WAITC(drive.limit === cbc_pkg::LIM_100MA)
      wc(32'h0);
      cyc(2);
      `CHK(drive.limit, lim)
      vbus(1'b0);
      pulse();
      wc(OFF);
      cyc(3);
      `CHK(drive.batsw_on, 1'b0)
      wc(32'h0);
      cyc(3);
      `CHK(drive.batsw_on, 1'b1)
      wc(OFF | DLY);
      cyc(5);
      `CHK(drive.batsw_on, 1'b1)
      cyc(40);
      `CHK(drive.batsw_on, 1'b0)
      push_button_pin_n <= 1'b0;
      cyc(12);
      push_button_pin_n <= 1'b1;
      cyc(3);
      `CHK(drive.batsw_on, 1'b1)
      wc(OFF | LEN);
      apb(1'b1, cbc_pkg::OFF_CTRL, 32'h1 << cbc_pkg::B_REG_RST);
      cyc(3);
      `CHK(drive.batsw_on, 1'b1)
      rd(cbc_pkg::OFF_CTRL, '1, 32'(cbc_pkg::CTRL_RST));
      wc(OFF | 32'h8);
      vbus(1'b1);
      pulse();
      `CHK(drive.batsw_on, 1'b1)
      vbus(1'b0);
      pulse();
      push_button_pin_n <= 1'b0;
      `WAITC(drive.batsw_on === 1'b0)
      n = 0;
      while (drive.batsw_on === 1'b0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      `CHK(n inside {[SW - 1:SW + 1]}, 1'b1)
      push_button_pin_n <= 1'b1;
      wc(32'h0);
      push_button_pin_n <= 1'b0;
      bad = 1'b0;
      repeat (55) begin
         @(posedge clk);
         bad = bad | (drive.batsw_on !== 1'b1);
      end
      `CHK(bad, 1'b0)
      push_button_pin_n <= 1'b1;
      ana.boost_mode <= 1'b1;
      ana.boost_tshut <= 1'b1;
      cyc(4);
      `CHK(drive.batsw_on, 1'b0)
      ana.boost_tshut <= 1'b0;
      cyc(3);
      `CHK(drive.batsw_on, 1'b0)
      wc(32'h0);
      cyc(3);
      `CHK(drive.batsw_on, 1'b1)
      report_and_stop();
   end
endmodule
`default_nettype wire
